/* hw/erw_early_read_wait_inserter.sv */
// erw_early_read_wait_inserter.sv: early-read wait state logic of a static memory controller
// assumes: the access sequencer offers one request at a time and waits for go or wait,
// and pulses write_end in the last cycle of every write
`include "erw_params.svh"

module erw_early_read_wait_inserter import erw_pkg::*; (
    // clock, reset, enable
    input  wire logic     ref_clk,
    input  wire logic     rst,
    input  wire logic     clk_en,
    // access request from the sequencer
    input  wire logic     req_valid,
    input  wire logic     req_write,
    input  wire erw_cs_t  req_cs,
    input  wire logic     req_cs_change,
    // per chip-select timing of the requested access
    input  wire logic     write_control_select,
    input  wire erw_tim_t write_strobe_hold_cycles,
    input  wire erw_tim_t cs_write_hold_cycles,
    input  wire erw_tim_t read_strobe_setup_cycles,
    input  wire erw_tim_t cs_read_setup_cycles,
    // write completion and strobe feedback
    input  wire logic     write_end,
    input  wire logic     write_strobe_n_fb,
    // answers to the sequencer
    output logic          req_ready,
    output logic          access_go,
    output logic          early_wait,
    output logic          cs_release,
    output logic          hold_extend,
    // status of the remembered access
    output logic          last_valid,
    output logic          last_write,
    output erw_cs_t       last_cs
);

    ////////////////////////////////////////////////////////////////////////////
    // decision logic
    // the decision module holds no state; it only sees what this module has
    // registered, the live late-strobe check and what the sequencer offers in the current cycle
    erw_dec_if dif ();

    erw_decide u_decide (
        .d (dif.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state
    erw_state_e state_r,         state_nxt;
    logic       ready_r,         ready_nxt;
    logic       go_r,            go_nxt;
    logic       wait_r,          wait_nxt;
    logic       cs_rel_r,        cs_rel_nxt;
    logic       hold_r,          hold_nxt;
    logic       lv_r,            lv_nxt;
    logic       lw_r,            lw_nxt;
    erw_cs_t    lcs_r,           lcs_nxt;
    logic       lmode_r,         lmode_nxt;
    logic       lwh0_r,          lwh0_nxt;
    logic       lch0_r,          lch0_nxt;
    logic       late_r,          late_nxt;
    logic       take;
    logic       fb_late_now;

    // request is taken only while ready is shown
    // clk_en is left out here: every register ignores take while it is low
    assign take = req_valid & ready_r & (state_r == ERW_IDLE);

    // strobe still low at the end of a no-hold strobe-controlled write
    // a heavily loaded strobe would otherwise overlap the next read; the
    // feedback is only trusted when the write had no hold of its own
    assign fb_late_now = write_end & (lmode_r == `ERW_MODE_STROBE) & lwh0_r
                       & ~write_strobe_n_fb;

    // feed the decision with the remembered write and the pending request
    assign dif.last_valid       = lv_r;
    assign dif.last_write       = lw_r;
    assign dif.last_cs          = lcs_r;
    assign dif.last_mode        = lmode_r;
    assign dif.last_we_hold0    = lwh0_r;
    assign dif.last_cs_hold0    = lch0_r;
    assign dif.last_fb_late     = late_r | fb_late_now;
    assign dif.req_read         = ~req_write;
    assign dif.req_cs           = req_cs;
    assign dif.req_rd_setup0    = (read_strobe_setup_cycles == `ERW_TIM_ZERO);
    assign dif.req_cs_rd_setup0 = (cs_read_setup_cycles == `ERW_TIM_ZERO);
    assign dif.req_cs_change    = req_cs_change;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: one idle cycle before a read that needs it
    // the decision is taken combinationally in the take cycle, so the read's own
    // setup values count and the write's values come from the record below.
    // while the idle cycle stands, ready is low, so a new request cannot slip
    // in between the wait and its access start.
    // trade-off: a read that needs the wait always costs one full cycle, even
    // when the write could have ended a little sooner on a fast device
    always_comb begin
        state_nxt  = state_r;
        ready_nxt  = ready_r;
        go_nxt     = 1'h0;
        wait_nxt   = 1'h0;
        cs_rel_nxt = 1'h0;
        case (state_r)
            ERW_IDLE: begin
                ready_nxt = 1'h1;
                if (take) begin
                    if (dif.need_wait) begin
                        state_nxt  = ERW_WAIT;
                        ready_nxt  = 1'h0;
                        wait_nxt   = 1'h1;
                        // cs is driven high in the idle cycle so a cs write ends
                        cs_rel_nxt = (lmode_r == `ERW_MODE_CS);
                    end else begin
                        go_nxt = 1'h1;
                    end
                end
            end
            ERW_WAIT: begin
                // the held read starts right after the idle cycle
                state_nxt = ERW_IDLE;
                ready_nxt = 1'h1;
                go_nxt    = 1'h1;
            end
            default: begin
                state_nxt = ERW_IDLE;
                ready_nxt = 1'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // remembered access and late-feedback hold
    // only the zero tests of the timing fields are kept, not the counts:
    // the wait decision never needs more than whether a field is zero.
    // the record is written when an access is taken, not when it completes,
    // so a read that follows at once already sees the write's settings
    always_comb begin
        lv_nxt    = lv_r;
        lw_nxt    = lw_r;
        lcs_nxt   = lcs_r;
        lmode_nxt = lmode_r;
        lwh0_nxt  = lwh0_r;
        lch0_nxt  = lch0_r;
        late_nxt  = late_r;
        // outputs stay one more cycle when the strobe came back late
        hold_nxt  = fb_late_now;
        if (fb_late_now) begin
            late_nxt = 1'h1;
        end
        // record every access as it starts; the read consumes the late flag,
        // but a late flag raised in the same cycle survives
        if (take) begin
            lv_nxt    = 1'h1;
            lw_nxt    = req_write;
            lcs_nxt   = req_cs;
            lmode_nxt = write_control_select;
            lwh0_nxt  = (write_strobe_hold_cycles == `ERW_TIM_ZERO);
            lch0_nxt  = (cs_write_hold_cycles == `ERW_TIM_ZERO);
            late_nxt  = fb_late_now & ~req_write;
            if (req_write) begin
                late_nxt = 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer registers; clk_en low freezes everything
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r  <= ERW_IDLE;
            ready_r  <= 1'h0;
            go_r     <= 1'h0;
            wait_r   <= 1'h0;
            cs_rel_r <= 1'h0;
        end else if (clk_en) begin
            state_r  <= state_nxt;
            ready_r  <= ready_nxt;
            go_r     <= go_nxt;
            wait_r   <= wait_nxt;
            cs_rel_r <= cs_rel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // record registers; the same freeze, so a stalled cycle never ages the record,
    // and the hold pulse stays up through it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_r   <= 1'h0;
            lv_r     <= 1'h0;
            lw_r     <= 1'h0;
            lcs_r    <= `ERW_CS_RST;
            lmode_r  <= `ERW_MODE_CS;
            lwh0_r   <= 1'h0;
            lch0_r   <= 1'h0;
            late_r   <= 1'h0;
        end else if (clk_en) begin
            hold_r   <= hold_nxt;
            lv_r     <= lv_nxt;
            lw_r     <= lw_nxt;
            lcs_r    <= lcs_nxt;
            lmode_r  <= lmode_nxt;
            lwh0_r   <= lwh0_nxt;
            lch0_r   <= lch0_nxt;
            late_r   <= late_nxt;
        end
    end

    // outputs straight from flops
    // no output passes through logic, so the sequencer sees clean levels
    assign req_ready   = ready_r;
    assign access_go   = go_r;
    assign early_wait  = wait_r;
    assign cs_release  = cs_rel_r;
    assign hold_extend = hold_r;
    assign last_valid  = lv_r;
    assign last_write  = lw_r;
    assign last_cs     = lcs_r;

endmodule : erw_early_read_wait_inserter

/* hw/erw_params.svh */
// erw_params.svh: widths, zero value, mode codes and reset values of the early-read wait inserter
// assumes: included by bare name from the package and the design modules
// How it works
// - insert idle cycle between write and read
// - no extra wait beside chip-select wait
// - only when same chip select follows
// - strobe hold zero, read setup zero: wait
// - cs mode: cs hold, read setup zero
// - cs mode: write ends by cs rise
// - strobe mode, hold zero: use strobe feedback
// - late feedback: wait, hold outputs one cycle
`ifndef ERW_PARAMS_SVH
`define ERW_PARAMS_SVH

`define ERW_CS_W        3
`define ERW_TIM_W       6
`define ERW_TIM_ZERO    6'h00
`define ERW_CS_RST      3'h0
`define ERW_MODE_CS     1'h0
`define ERW_MODE_STROBE 1'h1

`endif

/* hw/erw_pkg.sv */
// erw_pkg.sv: types shared by the early-read wait inserter modules
// assumes: erw_params.svh is on the include path
`include "erw_params.svh"

package erw_pkg;

    typedef logic [`ERW_CS_W-1:0]  erw_cs_t;
    typedef logic [`ERW_TIM_W-1:0] erw_tim_t;

    // sequencer states: idle, one inserted idle cycle
    typedef enum logic [0:0] {
        ERW_IDLE,
        ERW_WAIT
    } erw_state_e;

endpackage : erw_pkg

/* hw/erw_dec_if.sv */
// erw_dec_if.sv: carries the remembered access and the pending request to the decision logic
// assumes: top drives everything but need_wait, decision module drives need_wait
interface erw_dec_if import erw_pkg::*;;
    logic    last_valid;
    logic    last_write;
    erw_cs_t last_cs;
    logic    last_mode;
    logic    last_we_hold0;
    logic    last_cs_hold0;
    logic    last_fb_late;
    logic    req_read;
    erw_cs_t req_cs;
    logic    req_rd_setup0;
    logic    req_cs_rd_setup0;
    logic    req_cs_change;
    logic    need_wait;

    modport top (
        output last_valid, last_write, last_cs, last_mode, last_we_hold0,
        output last_cs_hold0, last_fb_late, req_read, req_cs, req_rd_setup0,
        output req_cs_rd_setup0, req_cs_change,
        input  need_wait
    );
    modport dec (
        input  last_valid, last_write, last_cs, last_mode, last_we_hold0,
        input  last_cs_hold0, last_fb_late, req_read, req_cs, req_rd_setup0,
        input  req_cs_rd_setup0, req_cs_change,
        output need_wait
    );
endinterface : erw_dec_if

/* hw/erw_decide.sv */
// erw_decide.sv: combinational early-read wait decision
// assumes: all inputs are stable registered or synchronous values of ref_clk
`include "erw_params.svh"

module erw_decide import erw_pkg::*; (
    erw_dec_if.dec d
);
    logic same_dev;
    logic c_strobe;
    logic c_cs;
    logic c_fb;

    // a write followed by a read to the same device is the only candidate
    assign same_dev = d.last_valid & d.last_write & d.req_read
                    & (d.last_cs == d.req_cs);
    // no strobe hold after the write and no setup before the read
    assign c_strobe = d.last_we_hold0 & d.req_rd_setup0;
    // cs-controlled write: cs must rise before the read, whatever the read mode
    assign c_cs     = (d.last_mode == `ERW_MODE_CS) & d.last_cs_hold0
                    & d.req_cs_rd_setup0;
    // strobe-controlled write with no hold whose fed-back strobe came back late
    assign c_fb     = (d.last_mode == `ERW_MODE_STROBE) & d.last_we_hold0
                    & d.last_fb_late;

    // a chip-select change wait already separates the accesses
    assign d.need_wait = same_dev & ~d.req_cs_change
                       & (c_strobe | c_cs | c_fb);

endmodule : erw_decide

/* verification/erw_assertions.sv */
// erw_assertions.sv: port-level checks of the early-read wait inserter
// assumes: per chip-select timing inputs stay constant between a write and the next read
module erw_chk import erw_pkg::*; (
    // clock, reset, enable
    input wire logic     ref_clk,
    input wire logic     rst,
    input wire logic     clk_en,
    // request and timing
    input wire logic     req_valid,
    input wire logic     req_write,
    input wire erw_cs_t  req_cs,
    input wire logic     req_cs_change,
    input wire logic     write_control_select,
    input wire erw_tim_t write_strobe_hold_cycles,
    input wire erw_tim_t cs_write_hold_cycles,
    input wire erw_tim_t read_strobe_setup_cycles,
    input wire erw_tim_t cs_read_setup_cycles,
    input wire logic     write_end,
    input wire logic     write_strobe_n_fb,
    // answers
    input wire logic     req_ready,
    input wire logic     access_go,
    input wire logic     early_wait,
    input wire logic     cs_release,
    input wire logic     hold_extend,
    input wire logic     last_valid,
    input wire logic     last_write,
    input wire erw_cs_t  last_cs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // take and read-after-write to the same chip select
    logic take;
    logic hit;
    assign take = clk_en && req_valid && req_ready;
    assign hit  = !req_write && last_valid && last_write && last_cs == req_cs && !req_cs_change;
    ////////////////////////////////////////////////////////////////////////////
    chk_wait_then_go: assert property (clk_en && early_wait
        |=> access_go && !early_wait)
        else $error("no access start after wait");
    chk_no_double: assert property (take && req_cs_change |=> !early_wait)
        else $error("wait added to chip-select wait");
    chk_same_cs_only: assert property (take && !hit |=> !early_wait)
        else $error("wait without same-cs read after write");
    chk_strobe_zero: assert property (take && hit
        && write_strobe_hold_cycles == 6'h00 && read_strobe_setup_cycles == 6'h00
        |=> early_wait ##1 access_go)
        else $error("missing wait for zero hold and setup");
    chk_cs_mode_zero: assert property (take && hit && !write_control_select
        && cs_write_hold_cycles == 6'h00 && cs_read_setup_cycles == 6'h00
        |=> early_wait && cs_release)
        else $error("missing wait in cs mode");
    chk_release_cause: assert property (cs_release |-> early_wait)
        else $error("release outside wait");
    chk_extend_cause: assert property (hold_extend && $past(clk_en)
        |-> $past(write_end && !write_strobe_n_fb))
        else $error("hold extend without late strobe");
    chk_record_upd: assert property (take
        |=> last_valid && last_write == $past(req_write) && last_cs == $past(req_cs))
        else $error("access record not updated");
endmodule : erw_chk

bind erw_early_read_wait_inserter erw_chk u_chk (
    .ref_clk                  (ref_clk),
    .rst                      (rst),
    .clk_en                   (clk_en),
    .req_valid                (req_valid),
    .req_write                (req_write),
    .req_cs                   (req_cs),
    .req_cs_change            (req_cs_change),
    .write_control_select     (write_control_select),
    .write_strobe_hold_cycles (write_strobe_hold_cycles),
    .cs_write_hold_cycles     (cs_write_hold_cycles),
    .read_strobe_setup_cycles (read_strobe_setup_cycles),
    .cs_read_setup_cycles     (cs_read_setup_cycles),
    .write_end                (write_end),
    .write_strobe_n_fb        (write_strobe_n_fb),
    .req_ready                (req_ready),
    .access_go                (access_go),
    .early_wait               (early_wait),
    .cs_release               (cs_release),
    .hold_extend              (hold_extend),
    .last_valid               (last_valid),
    .last_write               (last_write),
    .last_cs                  (last_cs)
);

/* verification/erw_mem_model.sv */
// erw_mem_model.sv: far-side device returning the write strobe feedback
// assumes: write_end marks the last write cycle; late asks for a slowly released strobe
module erw_mem_model (
    // control from the bench
    input  wire logic write_end,
    input  wire logic late,
    // fed-back strobe, idles high through its pull-up
    output logic      write_strobe_n_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    // a heavily loaded strobe is still low when the write should end
    assign write_strobe_n_fb = !(write_end && late);
endmodule : erw_mem_model

/* verification/tb_top.sv */
// tb_top.sv: self-checking bench of the early-read wait inserter
// assumes: erw_pkg compiled first; ports driven by non-blocking assignment at rising edges
module tb_top import erw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic     ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, req_valid = 1'h0, req_write = 1'h0;
    logic     req_cs_change = 1'h0, write_control_select = 1'h1, write_end = 1'h0, late = 1'h0;
    erw_cs_t  req_cs = 3'h0;
    erw_tim_t write_strobe_hold_cycles = 6'h00, cs_write_hold_cycles = 6'h00;
    erw_tim_t read_strobe_setup_cycles = 6'h00, cs_read_setup_cycles = 6'h00;
    logic     write_strobe_n_fb, req_ready, access_go, early_wait, cs_release, hold_extend;
    logic     last_valid, last_write;
    erw_cs_t  last_cs;
    int       fails = 0, n_compared = 0;
    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    erw_early_read_wait_inserter dut (
        .ref_clk                  (ref_clk),
        .rst                      (rst),
        .clk_en                   (clk_en),
        .req_valid                (req_valid),
        .req_write                (req_write),
        .req_cs                   (req_cs),
        .req_cs_change            (req_cs_change),
        .write_control_select     (write_control_select),
        .write_strobe_hold_cycles (write_strobe_hold_cycles),
        .cs_write_hold_cycles     (cs_write_hold_cycles),
        .read_strobe_setup_cycles (read_strobe_setup_cycles),
        .cs_read_setup_cycles     (cs_read_setup_cycles),
        .write_end                (write_end),
        .write_strobe_n_fb        (write_strobe_n_fb),
        .req_ready                (req_ready),
        .access_go                (access_go),
        .early_wait               (early_wait),
        .cs_release               (cs_release),
        .hold_extend              (hold_extend),
        .last_valid               (last_valid),
        .last_write               (last_write),
        .last_cs                  (last_cs)
    );
    erw_mem_model u_mem (
        .write_end         (write_end),
        .late              (late),
        .write_strobe_n_fb (write_strobe_n_fb)
    );
    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : chk
    // per chip-select timing, same for the write and the read that follows
    task automatic cfg(input logic m, input erw_tim_t wh, ch, rs, cr);
        @(posedge ref_clk);
        write_control_select <= m;
        write_strobe_hold_cycles <= wh;
        cs_write_hold_cycles <= ch;
        read_strobe_setup_cycles <= rs;
        cs_read_setup_cycles <= cr;
    endtask : cfg
    // one access, held until taken, then the answer is judged
    task automatic acc(input logic w, input erw_cs_t cs, input logic chg, ew, rel);
        int   n;
        logic rdy;
        n = 0;
        rdy = 1'h0;
        @(posedge ref_clk);
        req_valid <= 1'h1;
        req_write <= w;
        req_cs <= cs;
        req_cs_change <= chg;
        // ready is read mid-cycle, where it is settled, then the taking edge passes
        while (rdy !== 1'h1 && n < 20) begin
            #1;
            rdy = req_ready & clk_en;
            @(posedge ref_clk);
            n++;
        end
        if (rdy !== 1'h1) begin
            fails++;
            $display("FAIL %0t request never taken", $time);
        end
        req_valid <= 1'h0;
        #1;
        chk(early_wait, ew, "early wait");
        chk(cs_release, rel, "cs release");
        chk(access_go, !ew, "access start");
        chk(req_ready, !ew, "ready during wait");
        chk(last_valid === 1'h1 && last_cs === cs && last_write === w, 1'h1, "record");
        if (ew) begin
            @(posedge ref_clk);
            #1;
            chk(access_go, 1'h1, "start after wait");
            chk(req_ready, 1'h1, "ready after wait");
        end
    endtask : acc
    // end of a write, strobe released late or on time
    task automatic wend(input logic lt);
        @(posedge ref_clk);
        write_end <= 1'h1;
        late <= lt;
        @(posedge ref_clk);
        write_end <= 1'h0;
        late <= 1'h0;
        #1;
        chk(hold_extend, lt, "hold extend");
    endtask : wend
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_strobe_zero;
        cfg(1'h1, 6'h00, 6'h01, 6'h00, 6'h01);
        acc(1'h1, 3'h2, 1'h0, 1'h0, 1'h0);
        acc(1'h0, 3'h2, 1'h0, 1'h1, 1'h0);
    endtask : s_strobe_zero
    task automatic s_cs_mode;
        cfg(1'h0, 6'h03, 6'h00, 6'h02, 6'h00);
        acc(1'h1, 3'h3, 1'h0, 1'h0, 1'h0);
        acc(1'h0, 3'h3, 1'h0, 1'h1, 1'h1);
        acc(1'h1, 3'h3, 1'h0, 1'h0, 1'h0);
        acc(1'h0, 3'h3, 1'h1, 1'h0, 1'h0);
        acc(1'h1, 3'h4, 1'h0, 1'h0, 1'h0);
        acc(1'h0, 3'h5, 1'h0, 1'h0, 1'h0);
        acc(1'h0, 3'h5, 1'h0, 1'h0, 1'h0);
    endtask : s_cs_mode
    task automatic s_late;
        cfg(1'h1, 6'h00, 6'h01, 6'h02, 6'h02);
        acc(1'h1, 3'h1, 1'h0, 1'h0, 1'h0);
        wend(1'h1);
        acc(1'h0, 3'h1, 1'h0, 1'h1, 1'h0);
        acc(1'h1, 3'h1, 1'h0, 1'h0, 1'h0);
        wend(1'h0);
        acc(1'h0, 3'h1, 1'h0, 1'h0, 1'h0);
    endtask : s_late
    // clk_en low stalls a pending request; it is taken once clk_en returns
    task automatic s_freeze;
        @(posedge ref_clk);
        clk_en <= 1'h0;
        req_valid <= 1'h1;
        req_write <= 1'h1;
        req_cs <= 3'h6;
        req_cs_change <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(access_go === 1'h0 && last_cs !== 3'h6, 1'h1, "taken while frozen");
        @(posedge ref_clk);
        clk_en <= 1'h1;
        @(posedge ref_clk);
        req_valid <= 1'h0;
        #1;
        chk(access_go === 1'h1 && last_cs === 3'h6, 1'h1, "start after freeze");
    endtask : s_freeze
    // verdict, the only place the run ends
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        chk(req_ready | last_valid, 1'h0, "outputs in reset");
        rst <= 1'h0;
        s_strobe_zero();
        s_cs_mode();
        s_late();
        s_freeze();
        stop_test();
    end
    // about 50 cycles expected; cut a hang well beyond that
    initial begin
        #5000;
        fails++;
        stop_test();
    end
endmodule : tb_top
